// ---- blr_pkg.sv ----
// Package: constants and types of the overhead routing and register bank
package blr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] BLR_IDX_DEVICE_IDENTITY = 8'h00;
    localparam logic [7:0] BLR_IDX_MASTER_CONFIG_ONE = 8'h01;
    localparam logic [7:0] BLR_IDX_MASTER_CONFIG_TWO = 8'h02;
    localparam logic [7:0] BLR_IDX_TRANSMIT_PIN_CONFIG = 8'h03;
    localparam logic [7:0] BLR_IDX_RECEIVE_PIN_CONFIG = 8'h04;
    localparam logic [7:0] BLR_IDX_LINE_PIN_CONFIG = 8'h05;
    localparam logic [7:0] BLR_IDX_INTERRUPT_SOURCE = 8'h06;
    localparam logic [7:0] BLR_IDX_MASTER_STATUS = 8'h08;
    localparam logic [7:0] BLR_IDX_MASTER_STATUS_LATCHED = 8'h09;
    localparam logic [7:0] BLR_IDX_MASTER_STATUS_IRQ_ENABLE = 8'h0A;
    localparam logic [7:0] BLR_IDX_TESTER_CONTROL_ONE = 8'h0B;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] BLR_RST_MC1 = 8'h04;
    localparam logic [7:0] BLR_RST_ZERO = 8'h00;
    // Identity value is arbitrary
    localparam logic [7:0] BLR_DEVICE_ID = 8'h5A;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned BLR_MC1_RST = 0;
    localparam int unsigned BLR_MC1_TUA1 = 2;
    localparam int unsigned BLR_MC2_PLB = 0;
    localparam int unsigned BLR_MC2_LLB = 1;
    localparam int unsigned BLR_MC2_DLB = 2;
    localparam int unsigned BLR_MC5_TPOSI = 1;
    localparam int unsigned BLR_MC5_TNEGI = 2;
    localparam int unsigned BLR_MC5_TPOSH = 3;
    localparam int unsigned BLR_MC5_TNEGH = 4;
    localparam int unsigned BLR_MC5_RPOSI = 6;
    localparam int unsigned BLR_MC5_RNEGI = 7;
    localparam int unsigned BLR_MSR_LOTC = 6;
    localparam int unsigned BLR_MSR_LORC = 7;
    localparam int unsigned BLR_TCR_EN = 0;
    localparam int unsigned BLR_TCR_MODE = 1;
    localparam int unsigned BLR_ISR_INT1 = 0;

    // ------------------------------------------------------------------
    // Timing: a line clock silent this long counts as lost
    // ------------------------------------------------------------------
    localparam int unsigned BLR_CLK_PERIOD_NS = 4;
    localparam int unsigned BLR_LOC_TIME_NS = 64;
    localparam int unsigned BLR_LOC_CYC = BLR_LOC_TIME_NS / BLR_CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Tester modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        BLR_TM_PAYLOAD = 2'h0,
        BLR_TM_OVERHEAD = 2'h1,
        BLR_TM_PAYLOAD_TX = 2'h2,
        BLR_TM_FULL = 2'h3
    } blr_mode_e;

endpackage

// ---- blr_overhead_route.sv ----
// Module: overhead bit routing between line, framer, tester and registers
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
module blr_overhead_route
    import blr_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    // Line side, from and to the line interface unit
    input wire logic rx_line_clk_i,
    input wire logic rx_line_pos_rail_i,
    input wire logic rx_line_neg_rail_i,
    input wire logic tx_line_clk_i,
    output logic tx_line_pos_rail_o,
    output logic tx_line_neg_rail_o,
    // System side
    input wire logic tx_system_data_in_i,
    output logic rx_system_data_out_o,
    // Framing logic, same clock
    input wire logic rx_oh_pos_i,
    input wire logic tx_oh_pos_i,
    input wire logic tx_cbit_pos_i,
    input wire logic m23_or_e3_i,
    input wire logic fmt_bit_i,
    output logic framer_bit_o,
    output logic framer_bit_vld_o,
    // Bit error tester, same clock
    input wire logic tester_gen_bit_i,
    output logic tester_bit_o,
    output logic tester_bit_vld_o,
    output logic tester_enable_o,
    output logic [1:0] tester_mode_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rx_clk_s;   // Line clock sync and edge stage
        logic [2:0] tx_clk_s;
        logic [1:0] rx_pos_s;   // Rail syncs, same depth as clock
        logic [1:0] rx_neg_s;
        logic [1:0] tx_system_data_in_s;
        logic tx_pos;           // Transmit rails
        logic tx_neg;
        logic tx_pre;           // Stream before all-ones, for diag loop
        logic rx_system_data_out;
        logic framer_bit;
        logic framer_vld;
        logic tester_bit;
        logic tester_vld;
        logic [7:0] mc1;
        logic [7:0] mc2;
        logic [7:0] mc3;
        logic [7:0] mc4;
        logic [7:0] mc5;
        logic [7:0] master_status_latched;
        logic [7:0] master_status_irq_enable;
        logic [7:0] tcr;
        logic [7:0] rx_idle;    // Cycles since last line clock edge
        logic [7:0] tx_idle;
        logic lorc;
        logic lotc;
        logic [31:0] prdata;
    } blr_state_s;

    blr_state_s st_q;
    blr_state_s st_d;

    // Decoded selects
    logic diag_loopback_en;
    logic line_loopback_en;
    logic tester_on;
    blr_mode_e mode_eff;
    logic rx_edge;
    logic tx_edge;
    logic rx_step;
    logic line_bit;
    logic fmt_oh;
    logic tx_pre;
    logic rx_bit;
    logic [7:0] reg_idx;
    logic addr_ok;
    logic wr_en;
    logic soft_rst;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    // Saturating idle counter step
    function automatic logic [7:0] idle_step(input logic edge_seen,
                                             input logic [7:0] cnt);
        if (edge_seen) begin
            idle_step = 8'h00;
        end else if (cnt == 8'hFF) begin
            idle_step = cnt;
        end else begin
            idle_step = cnt + 8'h01;
        end
    endfunction

    // Register readback by index
    function automatic logic [7:0] reg_read(input blr_state_s s,
                                            input logic [7:0] idx);
        logic [7:0] master_status;
        master_status = 8'h00;
        master_status[BLR_MSR_LORC] = s.lorc;
        master_status[BLR_MSR_LOTC] = s.lotc;
        case (idx)
            BLR_IDX_DEVICE_IDENTITY: reg_read = BLR_DEVICE_ID;
            BLR_IDX_MASTER_CONFIG_ONE: reg_read = s.mc1;
            BLR_IDX_MASTER_CONFIG_TWO: reg_read = s.mc2;
            BLR_IDX_TRANSMIT_PIN_CONFIG: reg_read = s.mc3;
            BLR_IDX_RECEIVE_PIN_CONFIG: reg_read = s.mc4;
            BLR_IDX_LINE_PIN_CONFIG: reg_read = s.mc5;
            BLR_IDX_INTERRUPT_SOURCE: begin
                reg_read = 8'h00;
                reg_read[BLR_ISR_INT1] = |(s.master_status_latched & s.master_status_irq_enable);
            end
            BLR_IDX_MASTER_STATUS: reg_read = master_status;
            BLR_IDX_MASTER_STATUS_LATCHED: reg_read = s.master_status_latched;
            BLR_IDX_MASTER_STATUS_IRQ_ENABLE: reg_read = s.master_status_irq_enable;
            BLR_IDX_TESTER_CONTROL_ONE: reg_read = s.tcr;
            default: reg_read = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Select decode and bus decode
    // ------------------------------------------------------------------
    // Plain gates so a mode change lands on the very next bit position
    always_comb begin
        diag_loopback_en = st_q.mc2[BLR_MC2_DLB];
        line_loopback_en = st_q.mc2[BLR_MC2_LLB];
        tester_on = st_q.tcr[BLR_TCR_EN];
        mode_eff = tester_on
            ? blr_mode_e'(st_q.tcr[BLR_TCR_MODE +: 2])
            : BLR_TM_PAYLOAD;
        rx_edge = st_q.rx_clk_s[1] & ~st_q.rx_clk_s[2];
        tx_edge = st_q.tx_clk_s[1] & ~st_q.tx_clk_s[2];
        // Diagnostic loopback runs the receiver off the transmit clock;
        // payload loopback has no say here, so diagnostic always wins
        rx_step = diag_loopback_en ? tx_edge : rx_edge;
        line_bit = (st_q.rx_pos_s[1] ^ st_q.mc5[BLR_MC5_RPOSI])
                 | (st_q.rx_neg_s[1] ^ st_q.mc5[BLR_MC5_RNEGI]);
        // C bits copied from transmit input, except in mode 01 where the tester fills overhead
        fmt_oh = (m23_or_e3_i & tx_cbit_pos_i)
               ? st_q.tx_system_data_in_s[1] : fmt_bit_i;
        // Tester fills overhead in mode 01, else the formatter
        if (tx_oh_pos_i && mode_eff == BLR_TM_OVERHEAD) begin
            tx_pre = tester_gen_bit_i;
        end else if (tx_oh_pos_i) begin
            tx_pre = fmt_oh;
        end else begin
            tx_pre = fmt_bit_i;
        end
        // Receive source: looped transmit stream or the line
        rx_bit = diag_loopback_en ? st_q.tx_pre : line_bit;
        reg_idx = 8'(paddr_i[ADDR_W-1:2]);
        addr_ok = (paddr_i[1:0] == 2'h0)
               && (paddr_i[ADDR_W-1:2]
                   <= (ADDR_W-2)'(BLR_IDX_TESTER_CONTROL_ONE))
               && (reg_idx != 8'h07);
        wr_en = psel_i & penable_i & pwrite_i & addr_ok;
        soft_rst = st_q.mc1[BLR_MC1_RST];
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Line clock and rail synchronisers
        st_d.rx_clk_s = {st_q.rx_clk_s[1:0], rx_line_clk_i};
        st_d.tx_clk_s = {st_q.tx_clk_s[1:0], tx_line_clk_i};
        st_d.rx_pos_s = {st_q.rx_pos_s[0], rx_line_pos_rail_i};
        st_d.rx_neg_s = {st_q.rx_neg_s[0], rx_line_neg_rail_i};
        st_d.tx_system_data_in_s = {st_q.tx_system_data_in_s[0], tx_system_data_in_i};
        st_d.framer_vld = 1'b0;
        st_d.tester_vld = 1'b0;
        // Transmit side, one bit per transmit clock edge
        if (tx_edge) begin
            st_d.tx_pre = tx_pre;
            if (line_loopback_en) begin
                // Raw rails out; formatter and tester output reach only the diag tap
                st_d.tx_pos = st_q.rx_pos_s[1];
                st_d.tx_neg = st_q.rx_neg_s[1];
            end else if (st_q.mc1[BLR_MC1_TUA1]) begin
                // Unframed all ones, applied after the diag tap
                st_d.tx_pos = 1'b1;
                st_d.tx_neg = 1'b0;
            end else begin
                st_d.tx_pos = tx_pre;
                st_d.tx_neg = 1'b0;
            end
            // Transmit-input modes feed the tester here
            if (mode_eff == BLR_TM_FULL) begin
                st_d.tester_bit = st_q.tx_system_data_in_s[1];
                st_d.tester_vld = 1'b1;
            end else if (mode_eff == BLR_TM_PAYLOAD_TX && !tx_oh_pos_i) begin
                st_d.tester_bit = st_q.tx_system_data_in_s[1];
                st_d.tester_vld = 1'b1;
            end
        end
        // Receive side, one bit per receive step
        if (rx_step) begin
            st_d.framer_bit = rx_bit;
            st_d.framer_vld = 1'b1;
            // Tester result replaces receive output in mode 11, and off overhead positions in mode 10
            if (mode_eff == BLR_TM_FULL) begin
                st_d.rx_system_data_out = tester_gen_bit_i;
            end else if (mode_eff == BLR_TM_PAYLOAD_TX && !rx_oh_pos_i) begin
                st_d.rx_system_data_out = tester_gen_bit_i;
            end else begin
                st_d.rx_system_data_out = rx_bit;
            end
            // Received overhead reaches the tester only in mode 01
            if (mode_eff == BLR_TM_OVERHEAD
                || (mode_eff == BLR_TM_PAYLOAD && !rx_oh_pos_i)) begin
                st_d.tester_bit = rx_bit;
                st_d.tester_vld = 1'b1;
            end
        end
        // Loss of line clock, counted on the sync output only
        st_d.rx_idle = idle_step(st_q.rx_clk_s[1] ^ st_q.rx_clk_s[2],
                                 st_q.rx_idle);
        st_d.tx_idle = idle_step(st_q.tx_clk_s[1] ^ st_q.tx_clk_s[2],
                                 st_q.tx_idle);
        st_d.lorc = (st_q.rx_idle >= 8'(BLR_LOC_CYC));
        st_d.lotc = (st_q.tx_idle >= 8'(BLR_LOC_CYC));
        // Register writes on the APB access edge
        if (wr_en) begin
            case (reg_idx)
                BLR_IDX_MASTER_CONFIG_ONE: st_d.mc1 = pwdata_i[7:0];
                BLR_IDX_MASTER_CONFIG_TWO: st_d.mc2 = pwdata_i[7:0];
                BLR_IDX_TRANSMIT_PIN_CONFIG: st_d.mc3 = pwdata_i[7:0];
                BLR_IDX_RECEIVE_PIN_CONFIG: st_d.mc4 = pwdata_i[7:0];
                BLR_IDX_LINE_PIN_CONFIG: st_d.mc5 = pwdata_i[7:0];
                BLR_IDX_MASTER_STATUS_LATCHED:
                    st_d.master_status_latched = st_q.master_status_latched & ~pwdata_i[7:0];
                BLR_IDX_MASTER_STATUS_IRQ_ENABLE:
                    st_d.master_status_irq_enable = pwdata_i[7:0];
                BLR_IDX_TESTER_CONTROL_ONE: st_d.tcr = pwdata_i[7:0];
                default: st_d.tcr = st_q.tcr;  // Read-only indices
            endcase
        end
        // Rising loss events latch; set wins over a same-cycle clear
        st_d.master_status_latched[BLR_MSR_LORC] = st_d.master_status_latched[BLR_MSR_LORC]
                                | (st_d.lorc & ~st_q.lorc);
        st_d.master_status_latched[BLR_MSR_LOTC] = st_d.master_status_latched[BLR_MSR_LOTC]
                                | (st_d.lotc & ~st_q.lotc);
        // Read data captured in the setup phase
        if (psel_i && !penable_i) begin
            st_d.prdata = {24'h000000, reg_read(st_q, reg_idx)};
        end
        // Soft reset loads the bank reset values but keeps the reset bit itself
        if (soft_rst) begin
            st_d.mc1[7:1] = BLR_RST_MC1[7:1];
            st_d.mc2 = BLR_RST_ZERO;
            st_d.mc3 = BLR_RST_ZERO;
            st_d.mc4 = BLR_RST_ZERO;
            st_d.mc5 = BLR_RST_ZERO;
            st_d.master_status_latched = BLR_RST_ZERO;
            st_d.master_status_irq_enable = BLR_RST_ZERO;
            st_d.tcr = BLR_RST_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Synchronous reset, constants only
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_q <= '0;
            st_q.mc1 <= BLR_RST_MC1;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        tx_line_pos_rail_o = (st_q.tx_pos ^ st_q.mc5[BLR_MC5_TPOSI])
                           | st_q.mc5[BLR_MC5_TPOSH];
        tx_line_neg_rail_o = (st_q.tx_neg ^ st_q.mc5[BLR_MC5_TNEGI])
                           | st_q.mc5[BLR_MC5_TNEGH];
        rx_system_data_out_o = st_q.rx_system_data_out;
        framer_bit_o = st_q.framer_bit;
        framer_bit_vld_o = st_q.framer_vld;
        tester_bit_o = st_q.tester_bit;
        tester_bit_vld_o = st_q.tester_vld;
        tester_enable_o = tester_on;
        tester_mode_o = st_q.tcr[BLR_TCR_MODE +: 2];
        irq_o = |(st_q.master_status_latched & st_q.master_status_irq_enable);
        prdata_o = st_q.prdata;
        // Zero-wait slave; unmapped words flag an error
        pready_o = 1'b1;
        pslverr_o = psel_i & penable_i & ~addr_ok;
    end

endmodule // blr_overhead_route
`default_nettype wire

// ---- blr_line_model.sv ----
// Partner model: line interface unit giving line clocks and receive rails
`timescale 1ns/10ps
`default_nettype none
module blr_line_model (
    // Control from the bench
    input wire logic run_i,
    input wire logic bit_i,
    // Line side toward the framer
    output logic rx_clk_o,
    output logic tx_clk_o,
    output logic rx_pos_o,
    output logic rx_neg_o
);
    logic mark_q; // Rail that carries the next mark
    // Receive clock, 48 ns, odd offset so no phase tie to the system clock
    initial begin
        rx_pos_o = 1'b0;
        rx_neg_o = 1'b0;
        mark_q = 1'b0;
        rx_clk_o = 1'b0;
        #7.3;
        forever #24 rx_clk_o = run_i ? ~rx_clk_o : 1'b0;
    end
    // Transmit clock, stands still with the receive one
    initial begin
        tx_clk_o = 1'b0;
        #13.1;
        forever #24 tx_clk_o = run_i ? ~tx_clk_o : 1'b0;
    end
    // Marks alternate between rails; change on falling edge to stay stable
    always @(negedge rx_clk_o) begin
        rx_pos_o <= bit_i & ~mark_q;
        rx_neg_o <= bit_i & mark_q;
        mark_q <= mark_q ^ bit_i;
    end
    // Stopped line: rails no longer carry the last data
    always @(negedge run_i) begin
        rx_pos_o <= ~rx_pos_o;
        rx_neg_o <= ~rx_neg_o;
    end
endmodule // blr_line_model
`default_nettype wire

// ---- blr_overhead_route_chk.sv ----
// Checker: port-level properties of the overhead routing block
`timescale 1ns/10ps
`default_nettype none
module blr_overhead_route_chk
    import blr_pkg::*;
#(
    parameter int unsigned ADDR_W = 12
) (
    // Clock, reset and bus
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o,
    // Line clocks and routed outputs
    input wire logic rx_line_clk_i,
    input wire logic tx_line_clk_i,
    input wire logic framer_bit_vld_o,
    input wire logic tester_bit_vld_o,
    input wire logic tester_enable_o,
    input wire logic [1:0] tester_mode_o
);
    // ------------------------------------------------------------------
    // Helper terms
    // ------------------------------------------------------------------
    logic acc; // Access phase
    logic wr_tcr; // Write to tester control
    assign acc = psel_i && penable_i;
    assign wr_tcr = acc && pwrite_i &&
        paddr_i == ADDR_W'({BLR_IDX_TESTER_CONTROL_ONE, 2'b00});
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ready_high: assert property (pready_o)
        else $error("ready low");
    a_err_unmapped: assert property (acc && (paddr_i[1:0] != 2'h0 ||
        paddr_i[ADDR_W-1:2] == (ADDR_W-2)'(8'h07)) |-> pslverr_o)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (acc && paddr_i ==
        ADDR_W'({BLR_IDX_MASTER_CONFIG_TWO, 2'b00}) |-> !pslverr_o)
        else $error("error on mapped access");
    a_rdata_upper: assert property (prdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_mode_write: assert property (wr_tcr |=>
        tester_mode_o == $past(pwdata_i[2:1])) else $error("mode not taken");
    a_enable_write: assert property (wr_tcr |=>
        tester_enable_o == $past(pwdata_i[0])) else $error("enable not taken");
    a_mode_hold: assert property ($changed({tester_enable_o,
        tester_mode_o}) |-> $past(wr_tcr)) else $error("mode moved alone");
    a_vld_pulse: assert property (framer_bit_vld_o |=>
        !framer_bit_vld_o) else $error("framer strobe too long");
    a_tvld_pulse: assert property (tester_bit_vld_o |=>
        !tester_bit_vld_o) else $error("tester strobe too long");
    a_vld_cause: assert property (framer_bit_vld_o |->
        $past(rx_line_clk_i, 2) || $past(tx_line_clk_i, 2))
        else $error("framer strobe without line clock");
    a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |=>
        !framer_bit_vld_o && !irq_o && tester_mode_o == 2'h0)
        else $error("outputs active in reset");
    // Main scenarios reached
    c_tcr_write: cover property (wr_tcr);
    c_bus_err: cover property (acc && pslverr_o);
    c_irq_rise: cover property ($rose(irq_o));
    c_tester_bit: cover property (tester_bit_vld_o);
endmodule // blr_overhead_route_chk
bind blr_overhead_route blr_overhead_route_chk #(.ADDR_W(ADDR_W)) i_chk (
    .clk_sys_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .rx_line_clk_i,
    .tx_line_clk_i, .framer_bit_vld_o, .tester_bit_vld_o, .tester_enable_o,
    .tester_mode_o);
`default_nettype wire

// ---- tb.sv ----
// Testbench: overhead routing, register bank and interrupt of one framer
`timescale 1ns/10ps
`default_nettype none
module tb;
    import blr_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic run, rx_bit, rclk, rx_line_pos_rail, rx_line_neg_rail, tclk, tx_line_pos_rail, tx_line_neg_rail, tx_system_data_in, rx_system_data_out;
    logic cb, fmt, gen, fbit, fvld, tbit, tvld, ten;
    logic [1:0] tmode;
    int mismatches = 0;
    int checked = 0;
    // Block under test; every bit position is overhead here
    blr_overhead_route i_dut (.clk_sys_i(clk), .nrst_i(nrst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
        .rx_line_clk_i(rclk), .rx_line_pos_rail_i(rx_line_pos_rail),
        .rx_line_neg_rail_i(rx_line_neg_rail), .tx_line_clk_i(tclk),
        .tx_line_pos_rail_o(tx_line_pos_rail), .tx_line_neg_rail_o(tx_line_neg_rail),
        .tx_system_data_in_i(tx_system_data_in), .rx_system_data_out_o(rx_system_data_out),
        .rx_oh_pos_i(1'b1), .tx_oh_pos_i(1'b1), .tx_cbit_pos_i(cb),
        .m23_or_e3_i(cb), .fmt_bit_i(fmt), .framer_bit_o(fbit),
        .framer_bit_vld_o(fvld), .tester_gen_bit_i(gen), .tester_bit_o(tbit),
        .tester_bit_vld_o(tvld), .tester_enable_o(ten), .tester_mode_o(tmode));
    // Line interface unit on the far side
    blr_line_model i_liu (.run_i(run), .bit_i(rx_bit), .rx_clk_o(rclk),
        .tx_clk_o(tclk), .rx_pos_o(rx_line_pos_rail), .rx_neg_o(rx_line_neg_rail));
    // 250 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; waits for ready, only the watchdog bounds it
    task automatic apb(input logic wr, input logic [7:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits for framer bit strobes, sampled mid-cycle to stay off the
    // launching edge; the watchdog bounds it
    task automatic wait_bits(input int n);
        int c;
        c = 0;
        while (c < n) begin
            @(negedge clk);
            if (fvld === 1'b1) c++;
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_bank();
        logic [31:0] d;
        logic e;
        apb(1'b1, BLR_IDX_DEVICE_IDENTITY, 32'hFF, d, e);
        apb(1'b0, BLR_IDX_DEVICE_IDENTITY, 32'h0, d, e);
        chk(d, {24'h0, BLR_DEVICE_ID});
        apb(1'b0, BLR_IDX_MASTER_CONFIG_ONE, 32'h0, d, e);
        chk(d, 32'h04);
        apb(1'b1, BLR_IDX_RECEIVE_PIN_CONFIG, 32'hA5, d, e);
        apb(1'b0, BLR_IDX_RECEIVE_PIN_CONFIG, 32'h0, d, e);
        chk(d, 32'hA5);
        apb(1'b0, 8'h07, 32'h0, d, e);
        chk({d[30:0], e}, 32'h1);
    endtask
    // Source codes: 0 line, 1 transmit input, 2 tester, 3 formatter, 4 none
    task automatic route(input logic [7:0] lb, input logic [7:0] tcr,
        input logic c, input int s_tx, input int s_fr, input int s_rd,
        input int s_tb);
        logic [31:0] d;
        logic e;
        logic [3:0] v, m;
        apb(1'b1, BLR_IDX_MASTER_CONFIG_TWO, {24'h0, lb}, d, e);
        apb(1'b1, BLR_IDX_TESTER_CONTROL_ONE, {24'h0, tcr}, d, e);
        @(negedge clk);
        chk(32'({tmode, ten}), 32'(tcr[2:0]));
        m = (s_tb > 3) ? 4'hE : 4'hF;
        // Two patterns tell every pair of sources apart
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            v = (k == 0) ? 4'h5 : 4'h3;
            rx_bit <= v[0];
            tx_system_data_in <= v[1];
            gen <= v[2];
            fmt <= v[3];
            cb <= c;
            wait_bits(4);
            chk(32'({tx_line_pos_rail | tx_line_neg_rail, fbit, rx_system_data_out, tbit} & m),
                32'({v[s_tx], v[s_fr], v[s_rd], v[s_tb]} & m));
        end
    endtask
    task automatic t_route();
        logic [31:0] d;
        logic e;
        // Unframed all ones off so the routed bits reach the line
        apb(1'b1, BLR_IDX_MASTER_CONFIG_ONE, 32'h0, d, e);
        route(8'h00, 8'h03, 1'b0, 2, 0, 0, 0);
        route(8'h02, 8'h03, 1'b0, 0, 0, 0, 0);
        route(8'h01, 8'h03, 1'b0, 2, 0, 0, 0);
        route(8'h00, 8'h07, 1'b0, 3, 0, 2, 1);
        route(8'h00, 8'h01, 1'b1, 1, 0, 0, 4);
        route(8'h00, 8'h07, 1'b1, 1, 0, 2, 1);
        route(8'h05, 8'h03, 1'b0, 2, 2, 2, 2);
        route(8'h06, 8'h03, 1'b0, 0, 2, 2, 4);
        route(8'h00, 8'h02, 1'b0, 3, 0, 0, 4);
        route(8'h00, 8'h05, 1'b0, 3, 0, 0, 4);
    endtask
    // Receive clock loss raises, masks and clears the interrupt
    task automatic t_irq();
        logic [31:0] d;
        logic e;
        apb(1'b1, BLR_IDX_MASTER_STATUS_IRQ_ENABLE, 32'h80, d, e);
        run <= 1'b0;
        repeat (40) @(posedge clk);
        apb(1'b0, BLR_IDX_MASTER_STATUS_LATCHED, 32'h0, d, e);
        chk(d & 32'h80, 32'h80);
        apb(1'b0, BLR_IDX_INTERRUPT_SOURCE, 32'h0, d, e);
        chk(32'({d[0], irq}), 32'h3);
        apb(1'b1, BLR_IDX_MASTER_STATUS_IRQ_ENABLE, 32'h0, d, e);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        apb(1'b1, BLR_IDX_MASTER_STATUS_IRQ_ENABLE, 32'h80, d, e);
        run <= 1'b1;
        repeat (40) @(posedge clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, BLR_IDX_MASTER_STATUS_LATCHED, 32'h80, d, e);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
    endtask
    // Verdict and end of run
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
    // Main sequence
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {rx_bit, tx_system_data_in, cb, fmt, gen} = '0;
        run = 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        t_bank();
        t_route();
        t_irq();
        test_done();
    end
endmodule // tb
`default_nettype wire
